/* core/hmtc_pkg.sv */
// Constants for the haptic mode and trigger control block.
// Assumes a single 40 MHz clock and registers reached over a two-wire serial bus.
`default_nettype none
package hmtc_pkg;
	localparam logic [7:0] ADDR_STATUS    = 8'h00;
	localparam logic [7:0] ADDR_MODE      = 8'h01;
	localparam logic [7:0] ADDR_LIVE      = 8'h02;
	localparam logic [7:0] ADDR_LAUNCH    = 8'h0c;
	localparam logic [7:0] ADDR_CTRL      = 8'h1d;
	localparam int         BIT_REINIT     = 7;
	localparam int         BIT_STANDBY    = 6;
	localparam int         BIT_OUTCOME    = 3;
	localparam int         BIT_FORMAT     = 3;
	localparam int         BIT_SRC_SEL    = 1;
	localparam logic       RST_STANDBY    = 1'b1;
	localparam logic [2:0] RST_MODE       = 3'h0;
	localparam logic [7:0] RST_LIVE       = 8'h00;
	localparam logic [2:0] MODE_INTERNAL  = 3'h0;
	localparam logic [2:0] MODE_EDGE      = 3'h1;
	localparam logic [2:0] MODE_LEVEL     = 3'h2;
	localparam logic [2:0] MODE_EXT_DRIVE = 3'h3;
	localparam logic [2:0] MODE_RESERVED  = 3'h4;
	localparam logic [2:0] MODE_LIVE      = 3'h5;
	localparam logic [2:0] MODE_DIAG      = 3'h6;
	localparam logic [2:0] MODE_CAL       = 3'h7;
	localparam logic [7:0] PWM_LAST       = 8'hfe;
	localparam logic [3:0] BITS_BYTE      = 4'h8;
	localparam logic [3:0] BITS_ACK       = 4'h9;
	typedef enum logic [6:0] {
		I2C_IDLE = 7'h01,
		I2C_ADDR = 7'h02,
		I2C_ACKA = 7'h04,
		I2C_REG  = 7'h08,
		I2C_ACKW = 7'h10,
		I2C_WR   = 7'h20,
		I2C_RD   = 7'h40
	} hmtc_i2c_e;
endpackage
`default_nettype wire

/* core/hmtc_pin_sync.sv */
// Two-stage synchroniser with edge detection for a group of pins.
// Assumes pins are asynchronous to the clock.
`default_nettype none
module hmtc_pin_sync #(
	parameter int               WIDTH = 3,
	parameter logic [WIDTH-1:0] IDLE  = '1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o,
	output logic      [WIDTH-1:0] rise_o,
	output logic      [WIDTH-1:0] fall_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			// Idle levels, no false edge after reset
			stage1 <= IDLE;
			stage2 <= IDLE;
			stage3 <= IDLE;
		end else begin
			stage1 <= pin_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign level_o = stage2;
	assign rise_o  = stage2 & ~stage3;
	assign fall_o  = ~stage2 & stage3;
endmodule
`default_nettype wire

/* core/hmtc_routine.sv */
// Timed diagnostic or calibration run with pass or fail capture.
// Assumes fail_i is valid, synchronous, at the end of the run.
`default_nettype none
module hmtc_routine #(
	parameter int RUN_CYCLES = 40000
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic start_i,
	input  wire logic abort_i,
	input  wire logic fail_i,
	output logic      busy_o,
	output logic      done_o,
	output logic      fail_o
);
	localparam int CW = $clog2(RUN_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(RUN_CYCLES - 1);
	logic [CW-1:0] count;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
			count  <= '0;
		end else begin
			done_o <= 1'b0;
			if (abort_i) begin
				busy_o <= 1'b0;
				count  <= '0;
			end else if (start_i && !busy_o) begin
				busy_o <= 1'b1;
				count  <= '0;
			end else if (busy_o) begin
				if (count == LAST) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
					fail_o <= fail_i;
				end else begin
					count <= count + 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* core/hmtc_top.sv */
// Mode register, launch bit and trigger handling with its serial register port.
// Assumes a playback engine, a feedback loop and an on-die converter on CLK_I.
`default_nettype none
module hmtc_top
	import hmtc_pkg::*;
#(
	// Bus address, value arbitrary
	parameter logic [6:0] DEV_ADDR      = 7'h3b,
	parameter int         REINIT_CYCLES = 16,
	parameter int         DIAG_CYCLES   = 40000,
	parameter int         CAL_CYCLES    = 40000
) (
	input  wire logic       CLK_I,
	input  wire logic       RST_B_I,
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE_B_O,
	input  wire logic       TRIG_I,
	input  wire logic [7:0] ANALOG_LEVEL_I,
	input  wire logic       PLAY_DONE_I,
	input  wire logic       CHECK_FAIL_I,
	output logic            STANDBY_O,
	output logic            PLAY_GO_O,
	output logic            PLAY_CANCEL_O,
	output logic            DRIVE_EN_O,
	output logic [7:0]      DRIVE_VAL_O,
	output logic            DRIVE_UNSIGNED_O,
	output logic            ROUTINE_RUN_O,
	output logic            ROUTINE_CAL_O,
	output logic            REINIT_O
);
	localparam int RW = $clog2(REINIT_CYCLES + 1);
	localparam logic [RW-1:0] REINIT_LAST = RW'(REINIT_CYCLES - 1);

	logic [2:0]    sy_level;
	logic [2:0]    sy_rise;
	logic [2:0]    sy_fall;
	hmtc_i2c_e     i2c_state;
	logic [3:0]    bit_cnt;
	logic [7:0]    shreg;
	logic [7:0]    ptr;
	logic          rw_read;
	logic          host_ack;
	logic          wr_pulse;
	logic [7:0]    wr_addr;
	logic [7:0]    wr_data;
	logic          rd_pulse;
	logic [7:0]    rd_addr;
	logic [7:0]    rd_data;
	logic          start_cond;
	logic          stop_cond;
	logic          reinit_busy;
	logic [RW-1:0] reinit_cnt;
	logic          standby;
	logic [2:0]    mode;
	logic [7:0]    live_value;
	logic          live_format;
	logic          src_sel;
	logic          go;
	logic          next_go;
	logic          play_start;
	logic          cancel;
	logic          diag_start;
	logic          cal_start;
	logic          outcome;
	logic [7:0]    pwm_win;
	logic [7:0]    pwm_high;
	logic [7:0]    pwm_value;
	logic          diag_busy;
	logic          diag_done;
	logic          diag_fail;
	logic          cal_busy;
	logic          cal_done;
	logic          cal_fail;
	logic          sw_go_wr;
	logic          is_play;

	// Index 0 clock, 1 data, 2 trigger
	hmtc_pin_sync #(.WIDTH(3), .IDLE(3'h3)) u_sync (
		.clk_i   (CLK_I),
		.rst_b_i (RST_B_I),
		.pin_i   ({TRIG_I, SDA_I, SCL_I}),
		.level_o (sy_level),
		.rise_o  (sy_rise),
		.fall_o  (sy_fall)
	);

	assign start_cond = sy_fall[1] & sy_level[0];
	assign stop_cond  = sy_rise[1] & sy_level[0];

	// Serial bus target state machine
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			i2c_state  <= I2C_IDLE;
			bit_cnt    <= 4'h0;
			shreg      <= 8'h00;
			ptr        <= 8'h00;
			rw_read    <= 1'b0;
			host_ack   <= 1'b0;
			SDA_OE_B_O <= 1'b1;
			wr_pulse   <= 1'b0;
			wr_addr    <= 8'h00;
			wr_data    <= 8'h00;
			rd_pulse   <= 1'b0;
			rd_addr    <= 8'h00;
		end else begin
			wr_pulse <= 1'b0;
			rd_pulse <= 1'b0;
			if (stop_cond) begin
				i2c_state  <= I2C_IDLE;
				SDA_OE_B_O <= 1'b1;
			end else if (start_cond) begin
				i2c_state  <= I2C_ADDR;
				bit_cnt    <= 4'h0;
				SDA_OE_B_O <= 1'b1;
			end else begin
				unique case (i2c_state)
					I2C_IDLE: begin
					end
					I2C_ADDR, I2C_REG, I2C_WR: begin
						if (sy_rise[0]) begin
							shreg   <= {shreg[6:0], sy_level[1]};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (sy_fall[0] && bit_cnt == BITS_BYTE) begin
							bit_cnt <= 4'h0;
							if (i2c_state == I2C_ADDR) begin
								if (shreg[7:1] == DEV_ADDR) begin
									rw_read    <= shreg[0];
									SDA_OE_B_O <= 1'b0;
									i2c_state  <= I2C_ACKA;
								end else begin
									i2c_state <= I2C_IDLE;
								end
							end else begin
								if (i2c_state == I2C_REG) begin
									ptr <= shreg;
								end else begin
									wr_pulse <= 1'b1;
									wr_addr  <= ptr;
									wr_data  <= shreg;
									ptr      <= ptr + 8'h01;
								end
								SDA_OE_B_O <= 1'b0;
								i2c_state  <= I2C_ACKW;
							end
						end
					end
					I2C_ACKA: begin
						if (sy_fall[0]) begin
							bit_cnt <= 4'h0;
							if (rw_read) begin
								shreg      <= rd_data;
								SDA_OE_B_O <= rd_data[7];
								rd_pulse   <= 1'b1;
								rd_addr    <= ptr;
								ptr        <= ptr + 8'h01;
								i2c_state  <= I2C_RD;
							end else begin
								SDA_OE_B_O <= 1'b1;
								i2c_state  <= I2C_REG;
							end
						end
					end
					I2C_ACKW: begin
						if (sy_fall[0]) begin
							SDA_OE_B_O <= 1'b1;
							i2c_state  <= I2C_WR;
						end
					end
					I2C_RD: begin
						if (sy_rise[0]) begin
							bit_cnt <= bit_cnt + 4'h1;
							if (bit_cnt == BITS_BYTE) begin
								host_ack <= ~sy_level[1];
							end
						end else if (sy_fall[0]) begin
							if (bit_cnt == BITS_BYTE) begin
								SDA_OE_B_O <= 1'b1;
							end else if (bit_cnt == BITS_ACK) begin
								if (host_ack) begin
									shreg      <= rd_data;
									SDA_OE_B_O <= rd_data[7];
									rd_pulse   <= 1'b1;
									rd_addr    <= ptr;
									ptr        <= ptr + 8'h01;
									bit_cnt    <= 4'h0;
								end else begin
									i2c_state <= I2C_IDLE;
								end
							end else begin
								SDA_OE_B_O <= shreg[3'h7 - bit_cnt[2:0]];
							end
						end
					end
					default: begin
						i2c_state  <= I2C_IDLE;
						SDA_OE_B_O <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			SDA_O <= 1'b0;
		end else begin
			SDA_O <= 1'b0;
		end
	end

	always_comb begin
		rd_data = 8'h00;
		unique case (ptr)
			ADDR_STATUS: rd_data[BIT_OUTCOME] = outcome;
			ADDR_MODE:   rd_data = {reinit_busy, standby, 3'h0, mode};
			ADDR_LIVE:   rd_data = live_value;
			ADDR_LAUNCH: rd_data[0] = go;
			ADDR_CTRL: begin
				rd_data[BIT_FORMAT]  = live_format;
				rd_data[BIT_SRC_SEL] = src_sel;
			end
			default:     rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			reinit_busy <= 1'b0;
			reinit_cnt  <= '0;
		end else if (reinit_busy) begin
			if (reinit_cnt == REINIT_LAST) begin
				reinit_busy <= 1'b0;
			end
			reinit_cnt <= reinit_cnt + 1'b1;
		end else if (wr_pulse && wr_addr == ADDR_MODE && wr_data[BIT_REINIT]) begin
			reinit_busy <= 1'b1;
			reinit_cnt  <= '0;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			standby     <= RST_STANDBY;
			mode        <= RST_MODE;
			live_value  <= RST_LIVE;
			live_format <= 1'b0;
			src_sel     <= 1'b0;
		end else if (reinit_busy) begin
			standby     <= RST_STANDBY;
			mode        <= RST_MODE;
			live_value  <= RST_LIVE;
			live_format <= 1'b0;
			src_sel     <= 1'b0;
		end else if (wr_pulse) begin
			if (wr_addr == ADDR_MODE && !wr_data[BIT_REINIT]) begin
				standby <= wr_data[BIT_STANDBY];
				mode    <= wr_data[2:0];
			end
			if (wr_addr == ADDR_LIVE) begin
				live_value <= wr_data;
			end
			if (wr_addr == ADDR_CTRL) begin
				live_format <= wr_data[BIT_FORMAT];
				src_sel     <= wr_data[BIT_SRC_SEL];
			end
		end
	end

	assign sw_go_wr = wr_pulse && wr_addr == ADDR_LAUNCH && !reinit_busy;
	assign is_play  = mode == MODE_INTERNAL || mode == MODE_EDGE || mode == MODE_LEVEL;

	always_comb begin
		next_go    = go;
		play_start = 1'b0;
		cancel     = 1'b0;
		diag_start = 1'b0;
		cal_start  = 1'b0;
		if (go && ((is_play && PLAY_DONE_I) || diag_done || cal_done)) begin
			next_go = 1'b0;
		end
		if (!standby) begin
			unique case (mode)
				MODE_INTERNAL: begin
					if (sw_go_wr && wr_data[0] && !go) begin
						next_go    = 1'b1;
						play_start = 1'b1;
					end else if (sw_go_wr && !wr_data[0] && go) begin
						next_go = 1'b0;
						cancel  = 1'b1;
					end
				end
				MODE_EDGE: begin
					if (sy_rise[2]) begin
						if (go) begin
							next_go = 1'b0;
							cancel  = 1'b1;
						end else begin
							next_go    = 1'b1;
							play_start = 1'b1;
						end
					end
				end
				MODE_LEVEL: begin
					if (sy_rise[2] && !go) begin
						next_go    = 1'b1;
						play_start = 1'b1;
					end else if (sy_fall[2] && go) begin
						next_go = 1'b0;
						cancel  = 1'b1;
					end
				end
				MODE_DIAG: begin
					if (sw_go_wr && wr_data[0] && !go) begin
						next_go    = 1'b1;
						diag_start = 1'b1;
					end
				end
				MODE_CAL: begin
					if (sw_go_wr && wr_data[0] && !go) begin
						next_go   = 1'b1;
						cal_start = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			go <= 1'b0;
		end else if (reinit_busy) begin
			go <= 1'b0;
		end else begin
			go <= next_go;
		end
	end

	hmtc_routine #(.RUN_CYCLES(DIAG_CYCLES)) u_diag (
		.clk_i   (CLK_I),
		.rst_b_i (RST_B_I),
		.start_i (diag_start),
		.abort_i (reinit_busy),
		.fail_i  (CHECK_FAIL_I),
		.busy_o  (diag_busy),
		.done_o  (diag_done),
		.fail_o  (diag_fail)
	);

	hmtc_routine #(.RUN_CYCLES(CAL_CYCLES)) u_cal (
		.clk_i   (CLK_I),
		.rst_b_i (RST_B_I),
		.start_i (cal_start),
		.abort_i (reinit_busy),
		.fail_i  (CHECK_FAIL_I),
		.busy_o  (cal_busy),
		.done_o  (cal_done),
		.fail_o  (cal_fail)
	);

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			outcome <= 1'b0;
		end else if (reinit_busy) begin
			outcome <= 1'b0;
		end else if (diag_done) begin
			outcome <= diag_fail;
		end else if (cal_done) begin
			outcome <= cal_fail;
		end else if (rd_pulse && rd_addr == ADDR_STATUS) begin
			outcome <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			pwm_win   <= 8'h00;
			pwm_high  <= 8'h00;
			pwm_value <= 8'h00;
		end else if (pwm_win == PWM_LAST) begin
			pwm_win   <= 8'h00;
			pwm_high  <= 8'h00;
			pwm_value <= pwm_high + {7'h00, sy_level[2]};
		end else begin
			pwm_win  <= pwm_win + 8'h01;
			pwm_high <= pwm_high + {7'h00, sy_level[2]};
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			STANDBY_O        <= RST_STANDBY;
			PLAY_GO_O        <= 1'b0;
			PLAY_CANCEL_O    <= 1'b0;
			DRIVE_EN_O       <= 1'b0;
			DRIVE_VAL_O      <= 8'h00;
			DRIVE_UNSIGNED_O <= 1'b0;
			ROUTINE_RUN_O    <= 1'b0;
			ROUTINE_CAL_O    <= 1'b0;
			REINIT_O         <= 1'b0;
		end else begin
			STANDBY_O     <= standby;
			PLAY_GO_O     <= go && is_play && !reinit_busy;
			PLAY_CANCEL_O <= cancel || (wr_pulse && wr_addr == ADDR_MODE && wr_data[BIT_REINIT]);
			REINIT_O      <= reinit_busy;
			ROUTINE_RUN_O <= diag_busy || cal_busy;
			ROUTINE_CAL_O <= cal_busy;
			DRIVE_EN_O    <= 1'b0;
			DRIVE_VAL_O   <= 8'h00;
			DRIVE_UNSIGNED_O <= 1'b0;
			if (!standby && !reinit_busy) begin
				if (mode == MODE_EXT_DRIVE) begin
					DRIVE_EN_O       <= 1'b1;
					DRIVE_VAL_O      <= src_sel ? ANALOG_LEVEL_I : pwm_value;
					DRIVE_UNSIGNED_O <= 1'b1;
				end else if (mode == MODE_LIVE) begin
					DRIVE_EN_O       <= 1'b1;
					DRIVE_VAL_O      <= live_value;
					DRIVE_UNSIGNED_O <= live_format;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* tb/hmtc_props.sv */
// Concurrent checks on the outputs of the mode and trigger control top.
// Assumes the top's clock, reset and status outputs only.
`default_nettype none
module hmtc_props #(
	parameter int REINIT_CYCLES = 16,
	parameter int DIAG_CYCLES   = 40000,
	parameter int CAL_CYCLES    = 40000
) (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic STANDBY_O,
	input wire logic PLAY_GO_O,
	input wire logic PLAY_CANCEL_O,
	input wire logic DRIVE_EN_O,
	input wire logic ROUTINE_RUN_O,
	input wire logic ROUTINE_CAL_O,
	input wire logic REINIT_O
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RE_MAX  = REINIT_CYCLES + 4;
	localparam int RUN_MAX = ((DIAG_CYCLES > CAL_CYCLES) ? DIAG_CYCLES : CAL_CYCLES) + 4;
	int run_cnt;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	// Length of the current routine run
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) run_cnt <= 0;
		else if (ROUTINE_RUN_O) run_cnt <= run_cnt + 1;
		else run_cnt <= 0;
	end
	a_reinit_defaults: assert property (REINIT_O [*3] |->
		STANDBY_O && !PLAY_GO_O && !ROUTINE_RUN_O && !DRIVE_EN_O)
		else $error("outputs not at defaults during reinit");
	a_reinit_length: assert property ($rose(REINIT_O) |=> REINIT_O [*2])
		else $error("reinit too short");
	a_reinit_ends: assert property ($rose(REINIT_O) |-> ##[1:RE_MAX] !REINIT_O)
		else $error("reinit did not end");
	a_standby_no_drive: assert property (STANDBY_O && $past(STANDBY_O) |-> !DRIVE_EN_O)
		else $error("drive while in standby");
	a_standby_no_go: assert property ($rose(PLAY_GO_O) |-> !STANDBY_O)
		else $error("launch while in standby");
	a_modes_exclusive: assert property (PLAY_GO_O |-> !DRIVE_EN_O && !ROUTINE_RUN_O)
		else $error("launch with drive or routine");
	a_cal_is_run: assert property (ROUTINE_CAL_O |-> ROUTINE_RUN_O)
		else $error("calibration flag without run");
	a_routine_min: assert property ($rose(ROUTINE_RUN_O) |=> ROUTINE_RUN_O [*8])
		else $error("routine ended too early");
	a_routine_bounded: assert property (run_cnt <= RUN_MAX)
		else $error("routine ran too long");
	a_cancel_drops_go: assert property (PLAY_CANCEL_O |-> ##[0:1] !PLAY_GO_O)
		else $error("launch kept after cancel");
	c_reinit: cover property ($rose(REINIT_O));
	c_cal: cover property ($rose(ROUTINE_CAL_O));
	c_cancel: cover property (PLAY_CANCEL_O);
	c_drive: cover property ($rose(DRIVE_EN_O));
endmodule
bind hmtc_top hmtc_props #(
	.REINIT_CYCLES(REINIT_CYCLES),
	.DIAG_CYCLES  (DIAG_CYCLES),
	.CAL_CYCLES   (CAL_CYCLES)
) i_props (
	.CLK_I        (CLK_I),
	.RST_B_I      (RST_B_I),
	.STANDBY_O    (STANDBY_O),
	.PLAY_GO_O    (PLAY_GO_O),
	.PLAY_CANCEL_O(PLAY_CANCEL_O),
	.DRIVE_EN_O   (DRIVE_EN_O),
	.ROUTINE_RUN_O(ROUTINE_RUN_O),
	.ROUTINE_CAL_O(ROUTINE_CAL_O),
	.REINIT_O     (REINIT_O)
);
`default_nettype wire

/* tb/hmtc_host.sv */
// Host model: two-wire bus master with register write and read tasks.
// Assumes a pulled-up data wire; all changes at the falling clock edge.
`default_nettype none
module hmtc_host #(
	parameter logic [6:0] ADDR = 7'h3b
) (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o,
	output int        nak_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		nak_cnt = 0;
	end
	task automatic hp;
		repeat (8) @(negedge clk_i);
	endtask
	task automatic tx(input logic b);
		@(negedge clk_i);
		sda_o = b;
		hp();
		scl_o = 1'b1;
		hp();
		scl_o = 1'b0;
	endtask
	task automatic rx(output logic b);
		@(negedge clk_i);
		sda_o = 1'b1;
		hp();
		scl_o = 1'b1;
		hp();
		b = sda_i;
		scl_o = 1'b0;
	endtask
	task automatic sta;
		@(negedge clk_i);
		sda_o = 1'b1;
		hp();
		scl_o = 1'b1;
		hp();
		sda_o = 1'b0;
		hp();
		scl_o = 1'b0;
	endtask
	task automatic sto;
		@(negedge clk_i);
		sda_o = 1'b0;
		hp();
		scl_o = 1'b1;
		hp();
		sda_o = 1'b1;
		hp();
	endtask
	task automatic wb(input logic [7:0] v);
		logic a;
		for (int i = 7; i >= 0; i--) tx(v[i]);
		rx(a);
		if (a !== 1'b0) nak_cnt++;
	endtask
	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		sta();
		wb({ADDR, 1'b0});
		wb(r);
		wb(d);
		sto();
	endtask
	task automatic rd(input logic [7:0] r, output logic [7:0] d);
		sta();
		wb({ADDR, 1'b0});
		wb(r);
		sta();
		wb({ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) rx(d[i]);
		tx(1'b1);
		sto();
	endtask
endmodule
`default_nettype wire

/* tb/hmtc_top_tb.sv */
// Testbench: mode register, launch bit, trigger modes and soft reset.
// Assumes the host model for the bus; the bench drives the trigger pin.
`default_nettype none
module hmtc_top_tb
	import hmtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Bus address, value arbitrary
	localparam logic [6:0] DEV = 7'h3b;
	logic CLK_I, RST_B_I, SDA_O, SDA_OE_B_O, TRIG_I, PLAY_DONE_I, CHECK_FAIL_I;
	logic STANDBY_O, PLAY_GO_O, PLAY_CANCEL_O, DRIVE_EN_O, DRIVE_UNSIGNED_O;
	logic ROUTINE_RUN_O, ROUTINE_CAL_O, REINIT_O, scl, hsda, sda_w;
	logic [7:0] ANALOG_LEVEL_I, DRIVE_VAL_O, d;
	int err_total, check_count, n_cancel, c0, naks;
	assign sda_w = hsda & (SDA_OE_B_O | SDA_O);
	hmtc_top #(.DEV_ADDR(DEV), .REINIT_CYCLES(64), .DIAG_CYCLES(200), .CAL_CYCLES(200)) i_dut (
		.CLK_I(CLK_I), .RST_B_I(RST_B_I), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(SDA_O),
		.SDA_OE_B_O(SDA_OE_B_O), .TRIG_I(TRIG_I), .ANALOG_LEVEL_I(ANALOG_LEVEL_I),
		.PLAY_DONE_I(PLAY_DONE_I), .CHECK_FAIL_I(CHECK_FAIL_I), .STANDBY_O(STANDBY_O),
		.PLAY_GO_O(PLAY_GO_O), .PLAY_CANCEL_O(PLAY_CANCEL_O), .DRIVE_EN_O(DRIVE_EN_O),
		.DRIVE_VAL_O(DRIVE_VAL_O), .DRIVE_UNSIGNED_O(DRIVE_UNSIGNED_O),
		.ROUTINE_RUN_O(ROUTINE_RUN_O), .ROUTINE_CAL_O(ROUTINE_CAL_O), .REINIT_O(REINIT_O));
	hmtc_host #(.ADDR(DEV)) i_host (.clk_i(CLK_I), .sda_i(sda_w), .scl_o(scl), .sda_o(hsda),
		.nak_cnt(naks));
	initial begin
		CLK_I = 1'b0;
		forever #12.5 CLK_I = ~CLK_I;
	end
	always @(posedge CLK_I) if (PLAY_CANCEL_O === 1'b1) n_cancel++;
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic trg(input logic v);
		TRIG_I = v;
		repeat (6) @(negedge CLK_I);
	endtask
	task automatic done_pulse;
		PLAY_DONE_I = 1'b1;
		@(negedge CLK_I);
		PLAY_DONE_I = 1'b0;
		repeat (2) @(negedge CLK_I);
	endtask
	task automatic routine(input logic f, input logic [7:0] m);
		CHECK_FAIL_I = f;
		i_host.wr(ADDR_MODE, m);
		i_host.wr(ADDR_LAUNCH, 8'h01);
		chk("run", 8'h01, 8'(ROUTINE_RUN_O));
		chk("cal", 8'(m[0]), 8'(ROUTINE_CAL_O));
		for (int i = 0; i < 400 && ROUTINE_RUN_O !== 1'b0; i++) @(negedge CLK_I);
		i_host.rd(ADDR_LAUNCH, d);
		chk("launch clr", 8'h00, d);
		i_host.rd(ADDR_STATUS, d);
		chk("outcome", 8'(f), 8'(d[BIT_OUTCOME]));
	endtask
	initial begin
		repeat (80000) @(posedge CLK_I);
		err_total++;
		final_report();
	end
	initial begin
		RST_B_I = 1'b0;
		TRIG_I = 1'b0;
		ANALOG_LEVEL_I = 8'h5a;
		PLAY_DONE_I = 1'b0;
		CHECK_FAIL_I = 1'b0;
		err_total = 0;
		check_count = 0;
		n_cancel = 0;
		repeat (12) @(negedge CLK_I);
		RST_B_I = 1'b1;
		repeat (4) @(negedge CLK_I);
		chk("standby rst", 8'h01, 8'(STANDBY_O));
		i_host.rd(ADDR_MODE, d);
		chk("mode rst", 8'h40, d);
		i_host.rd(8'h7f, d);
		chk("unmapped", 8'h00, d);
		i_host.wr(ADDR_LAUNCH, 8'h01);
		chk("standby go", 8'h00, 8'(PLAY_GO_O));
		i_host.wr(ADDR_MODE, 8'h00);
		chk("ready", 8'h00, 8'(STANDBY_O));
		i_host.wr(ADDR_LAUNCH, 8'h01);
		chk("go int", 8'h01, 8'(PLAY_GO_O));
		done_pulse();
		chk("go done", 8'h00, 8'(PLAY_GO_O));
		i_host.wr(ADDR_LAUNCH, 8'h01);
		c0 = n_cancel;
		i_host.wr(ADDR_LAUNCH, 8'h00);
		chk("cancel int", 8'(c0 + 1), 8'(n_cancel));
		chk("go int off", 8'h00, 8'(PLAY_GO_O));
		i_host.wr(ADDR_MODE, 8'h01);
		trg(1'b1);
		chk("go edge", 8'h01, 8'(PLAY_GO_O));
		trg(1'b0);
		c0 = n_cancel;
		trg(1'b1);
		chk("go edge2", 8'h00, 8'(PLAY_GO_O));
		chk("cancel edge", 8'(c0 + 1), 8'(n_cancel));
		trg(1'b0);
		i_host.wr(ADDR_MODE, 8'h02);
		trg(1'b1);
		chk("go level", 8'h01, 8'(PLAY_GO_O));
		c0 = n_cancel;
		trg(1'b0);
		chk("go fall", 8'h00, 8'(PLAY_GO_O));
		chk("cancel fall", 8'(c0 + 1), 8'(n_cancel));
		trg(1'b1);
		done_pulse();
		c0 = n_cancel;
		trg(1'b0);
		chk("no cancel", 8'(c0), 8'(n_cancel));
		i_host.wr(ADDR_CTRL, 8'h02);
		i_host.wr(ADDR_MODE, 8'h03);
		chk("en ext", 8'h01, 8'(DRIVE_EN_O));
		chk("analog", 8'h5a, DRIVE_VAL_O);
		chk("uns ext", 8'h01, 8'(DRIVE_UNSIGNED_O));
		i_host.wr(ADDR_CTRL, 8'h00);
		TRIG_I = 1'b1;
		repeat (600) @(negedge CLK_I);
		chk("pwm high", 8'hff, DRIVE_VAL_O);
		TRIG_I = 1'b0;
		repeat (600) @(negedge CLK_I);
		chk("pwm low", 8'h00, DRIVE_VAL_O);
		i_host.wr(ADDR_LIVE, 8'h9c);
		i_host.wr(ADDR_MODE, 8'h05);
		chk("en live", 8'h01, 8'(DRIVE_EN_O));
		chk("live", 8'h9c, DRIVE_VAL_O);
		chk("signed", 8'h00, 8'(DRIVE_UNSIGNED_O));
		i_host.wr(ADDR_CTRL, 8'h08);
		chk("unsigned", 8'h01, 8'(DRIVE_UNSIGNED_O));
		i_host.wr(ADDR_MODE, 8'h04);
		i_host.wr(ADDR_LAUNCH, 8'h01);
		chk("rsv go", 8'h00, 8'({PLAY_GO_O, DRIVE_EN_O, ROUTINE_RUN_O}));
		routine(1'b1, 8'h06);
		i_host.rd(ADDR_STATUS, d);
		chk("read clr", 8'h00, 8'(d[BIT_OUTCOME]));
		// Control register cleared before calibration launch
		i_host.wr(ADDR_CTRL, 8'h00);
		routine(1'b1, 8'h07);
		i_host.wr(ADDR_MODE, 8'h05);
		c0 = n_cancel;
		i_host.wr(ADDR_MODE, 8'h85);
		chk("reinit", 8'h01, 8'(REINIT_O));
		chk("abort", 8'h00, 8'(DRIVE_EN_O));
		chk("cancel rst", 8'(c0 + 1), 8'(n_cancel));
		for (int i = 0; i < 200 && REINIT_O !== 1'b0; i++) @(negedge CLK_I);
		i_host.rd(ADDR_MODE, d);
		chk("mode after", 8'h40, d);
		i_host.rd(ADDR_LIVE, d);
		chk("live after", RST_LIVE, d);
		chk("naks", 8'h00, 8'(naks));
		final_report();
	end
endmodule
`default_nettype wire
